// file: rtl/pscl_fix_note.sv
`timescale 1ns/1ps

// file: rtl/pscl_loader.sv
// Purpose: strap-pin configuration loader with host overwrite and output control
// Assumes: all inputs synchronous to clk (40 MHz); straps stable during reset
// Notes: page storage lives outside; this block walks it over a read port
`timescale 1ns/1ps
`default_nettype none
`include "pscl_regs.svh"
module pscl_loader #(
   parameter int NCH = 8
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic config_source_select, // 1 rom page mode, 0 eeprom mode
   input wire logic powerdown_input, // high holds the device powered down
   input wire logic [5:0] strap_two_state, // two-state strap levels
   input wire logic [1:0] strap1_tri, // three-state level of strap 1
   input wire logic [1:0] strap2_tri, // three-state level of strap 2
   input wire logic [1:0] strap3_tri, // three-state level of strap 3
   input wire logic [2:0] strap5_level, // eight-level code of strap 5
   output logic page_rd_req, // combinational read strobe
   output logic page_rd_rom, // 1 rom store, 0 eeprom store
   output logic [5:0] page_rd_page, // page index
   output logic [3:0] page_rd_word, // word within page
   input wire logic page_rd_valid, // read data present
   input wire logic [7:0] page_rd_data, // read data
   input wire logic host_wr_en, // host register update strobe
   input wire logic [3:0] host_wr_addr, // configuration word index
   input wire logic [7:0] host_wr_data, // new word value
   output logic host_ready, // combinational: updates accepted
   output logic host_if_en, // serial host interface enabled
   output logic [1:0] target_addr_lsb, // low bits of serial target address
   output logic margin_en, // frequency margining enable
   output logic [2:0] margin_sel, // margining offset select
   output logic page_invalid, // straps chose an invalid combination
   output logic [`PSCL_NWORDS*8-1:0] cfg_words, // live configuration image
   output logic div_sync, // one-cycle divider synchronisation pulse
   output logic outputs_enable, // clock drivers enabled
   input wire logic [NCH-1:0] src_valid, // per-channel selected source good
   output logic [NCH-1:0] ch_muted, // channel muted
   output logic [NCH-1:0] ch_mute_p, // muted positive node level
   output logic [NCH-1:0] ch_mute_n // muted negative node level
);

   // ===========================================================
   // elaboration check: mute words hold at most eight channels
   if (NCH < 1 || NCH > 8)
   begin : g_bad_nch
      $error("pscl_loader: NCH must be 1 to 8");
   end

   pscl_pkg::pscl_st_t q;
   pscl_pkg::pscl_st_t d;

   // ===========================================================
   // helpers
   // three-state address strap to address bits
   function automatic logic [1:0] addr_of(input logic [1:0] lvl);
      case (lvl)
         `PSCL_TRI_GND: addr_of = `PSCL_ADDR_GND;
         `PSCL_TRI_VDD: addr_of = `PSCL_ADDR_VDD;
         default: addr_of = `PSCL_ADDR_MID;
      endcase
   endfunction

   // page select: {page[2:0], use_default, bad}
   function automatic logic [4:0] page_of(input logic [1:0] hi, input logic [1:0] lo);
      case ({hi, lo})
         {`PSCL_TRI_GND, `PSCL_TRI_GND}: page_of = 5'h00;
         {`PSCL_TRI_GND, `PSCL_TRI_MID}: page_of = 5'h04;
         {`PSCL_TRI_GND, `PSCL_TRI_VDD}: page_of = 5'h08;
         {`PSCL_TRI_MID, `PSCL_TRI_GND}: page_of = 5'h0c;
         {`PSCL_TRI_MID, `PSCL_TRI_MID}: page_of = 5'h02;
         {`PSCL_TRI_MID, `PSCL_TRI_VDD}: page_of = 5'h10;
         {`PSCL_TRI_VDD, `PSCL_TRI_GND}: page_of = 5'h14;
         // remaining two codes are invalid: fall back to defaults
         default: page_of = 5'h03;
      endcase
   endfunction

   // page choice decoded from the two three-state page pins
   logic [4:0] psel;

   // ===========================================================
   // next-state logic
   always_comb
   begin
      // hold everything by default; sync is only ever a one-cycle pulse
      d = q;
      d.sync = 1'b0;
      psel = page_of(strap3_tri, strap2_tri);
      case (q.st)
         pscl_pkg::ST_RESET:
         begin
            d.outs_en = 1'b0;
            d.st = pscl_pkg::ST_LATCH;
         end
         pscl_pkg::ST_LATCH:
         begin
            // straps are caught once here and never again until reset
            d.rom_mode = config_source_select;
            d.widx = '0;
            d.cfg = `PSCL_CFG_DEFAULT;
            if (config_source_select)
            begin
               d.page = strap_two_state;
               d.use_default = 1'b0;
               d.page_bad = 1'b0;
               d.addr_lsb = `PSCL_ROM_ADDR_LSB;
               d.mrg_en = 1'b0;
               d.mrg_sel = '0;
            end
            else
            begin
               d.page = {3'h0, psel[4:2]};
               d.use_default = psel[1];
               d.page_bad = psel[0];
               d.addr_lsb = addr_of(strap1_tri);
               d.mrg_en = strap_two_state[4];
               d.mrg_sel = strap5_level;
            end
            // eeprom defaults or a bad page choice skip the page walk entirely
            d.st = (!config_source_select && psel[1]) ? pscl_pkg::ST_RUN : pscl_pkg::ST_LOAD_REQ;
         end
         pscl_pkg::ST_LOAD_REQ:
         begin
            // one read strobe per word, then wait for the answer
            d.st = pscl_pkg::ST_LOAD_WAIT;
         end
         pscl_pkg::ST_LOAD_WAIT:
         begin
            if (page_rd_valid)
            begin
               // word walk fills pll, input, mute and channel format settings
               d.cfg[q.widx*8 +: 8] = page_rd_data;
               d.widx = q.widx + 4'h1;
               d.st = (q.widx == `PSCL_W_LAST) ? pscl_pkg::ST_RUN : pscl_pkg::ST_LOAD_REQ;
            end
         end
         pscl_pkg::ST_RUN:
         begin
            d.outs_en = 1'b1;
            if (host_wr_en && host_wr_addr <= `PSCL_W_LAST)
            begin
               // writes past the last word are dropped silently
               d.cfg[host_wr_addr*8 +: 8] = host_wr_data;
            end
         end
         default:
         begin
            d.st = pscl_pkg::ST_RESET;
         end
      endcase
      // divider sync: rom mode on every entry to run (power-up or powerdown release)
      if (q.st != pscl_pkg::ST_RUN && d.st == pscl_pkg::ST_RUN && d.rom_mode)
      begin
         d.sync = 1'b1;
      end
      // eeprom mode: strap 0 falling edge requests sync
      d.output_sync_n_prev = strap_two_state[0];
      if (q.st == pscl_pkg::ST_RUN && !q.rom_mode && q.output_sync_n_prev && !strap_two_state[0])
      begin
         d.sync = 1'b1;
      end
      // powerdown acts as a power cycle, so a new mode pin level takes effect
      if (powerdown_input)
      begin
         d.st = pscl_pkg::ST_RESET;
         d.outs_en = 1'b0;
         d.sync = 1'b0;
      end
   end

   // ===========================================================
   // state register
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         q <= '{st: pscl_pkg::ST_RESET, rom_mode: 1'b0, page: 6'h00, use_default: 1'b0,
                page_bad: 1'b0, addr_lsb: 2'h0, mrg_en: 1'b0, mrg_sel: 3'h0, widx: 4'h0,
                cfg: `PSCL_CFG_DEFAULT, sync: 1'b0, output_sync_n_prev: 1'b1, outs_en: 1'b0};
      end
      else
      begin
         q <= d;
      end
   end

   // ===========================================================
   // outputs
   assign page_rd_req = (q.st == pscl_pkg::ST_LOAD_REQ);
   assign page_rd_rom = q.rom_mode;
   assign page_rd_page = q.page;
   assign page_rd_word = q.widx;
   // the host is refused in the very cycle powerdown rises
   assign host_ready = (q.st == pscl_pkg::ST_RUN) && !powerdown_input;
   // serial port stays on in both modes once loading is done
   assign host_if_en = (q.st == pscl_pkg::ST_RUN);
   assign target_addr_lsb = q.addr_lsb;
   assign margin_en = q.mrg_en;
   assign margin_sel = q.mrg_sel;
   assign page_invalid = q.page_bad;
   assign cfg_words = q.cfg;
   assign div_sync = q.sync;
   assign outputs_enable = q.outs_en;

   // ===========================================================
   // auto-mute driven from the live configuration image
   pscl_mute #(
      .NCH(NCH)
   ) u_mute (
      .clk(clk),
      .srst(srst),
      .src_valid(src_valid),
      .mute_en(q.cfg[`PSCL_W_CH_MUTE*8 +: NCH]),
      .mute_lvl(q.cfg[`PSCL_W_MUTE_LVL_LO*8 +: 2*NCH]),
      .is_diff(q.cfg[`PSCL_W_CH_FMT*8 +: NCH]),
      .muted(ch_muted),
      .mute_p(ch_mute_p),
      .mute_n(ch_mute_n)
   );

endmodule
`default_nettype wire

// file: rtl/pscl_mute.sv
// Purpose: per-channel auto-mute of clock output drivers
// Assumes: src_valid is already synchronous to clk
// Notes: levels are registered so drivers see no decode glitches
`timescale 1ns/1ps
`default_nettype none
module pscl_mute #(
   parameter int NCH = 8
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [NCH-1:0] src_valid, // selected source is good
   input wire logic [NCH-1:0] mute_en, // per-channel mute enable
   input wire logic [2*NCH-1:0] mute_lvl, // per-channel mute level
   input wire logic [NCH-1:0] is_diff, // 1 differential, 0 single-ended
   output logic [NCH-1:0] muted, // channel is in mute
   output logic [NCH-1:0] mute_p, // forced level of positive node
   output logic [NCH-1:0] mute_n // forced level of negative node
);

   logic [NCH-1:0] muted_d;
   logic [NCH-1:0] p_d;
   logic [NCH-1:0] n_d;

   // ===========================================================
   // mute decode
   always_comb
   begin
      for (int i = 0; i < NCH; i++)
      begin
         muted_d[i] = mute_en[i] & ~src_valid[i];
         if (is_diff[i])
         begin
            // level bit 0 raises the positive node, bit 1 grounds the negative
            p_d[i] = muted_d[i] & mute_lvl[2*i];
            n_d[i] = muted_d[i] & ~mute_lvl[2*i+1];
         end
         else
         begin
            // dc-coupled receivers must see a steady low, never a float
            p_d[i] = 1'b0;
            n_d[i] = 1'b0;
         end
      end
   end

   // ===========================================================
   // output registers
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         muted <= '0;
         mute_p <= '0;
         mute_n <= '0;
      end
      else
      begin
         muted <= muted_d;
         mute_p <= p_d;
         mute_n <= n_d;
      end
   end

endmodule
`default_nettype wire

// file: shared/pscl_pkg.sv
// Purpose: types of the strap-driven configuration loader
// Assumes: constants come from pscl_regs.svh
// Notes: the whole loader state is one packed struct
`default_nettype none
`include "pscl_regs.svh"
package pscl_pkg;

   // ===========================================================
   // loader states
   typedef enum logic [2:0] {
      ST_RESET,
      ST_LATCH,
      ST_LOAD_REQ,
      ST_LOAD_WAIT,
      ST_RUN
   } pscl_state_t;

   // ===========================================================
   // full register state of the loader
   typedef struct packed {
      pscl_state_t st;
      logic rom_mode;
      logic [5:0] page;
      logic use_default;
      logic page_bad;
      logic [1:0] addr_lsb;
      logic mrg_en;
      logic [2:0] mrg_sel;
      logic [3:0] widx;
      logic [`PSCL_NWORDS*8-1:0] cfg;
      logic sync;
      logic output_sync_n_prev;
      logic outs_en;
   } pscl_st_t;

endpackage
`default_nettype wire

// file: shared/pscl_regs.svh
// Purpose: constants of the strap-driven configuration loader
// Assumes: one clock, straps stable while reset is high
// Notes: three-state strap codes are 2'h0 ground, 2'h1 mid/float, 2'h2 supply
`ifndef PSCL_REGS_SVH
`define PSCL_REGS_SVH

// ===========================================================
// configuration word layout (8-bit words)
`define PSCL_NWORDS 10
`define PSCL_W_PLL_NDIV 4'h0
`define PSCL_W_PLL_DBL 4'h1
`define PSCL_W_PLL_PD 4'h2
`define PSCL_W_IN_TYPE 4'h3
`define PSCL_W_IN_MUX 4'h4
`define PSCL_W_REF_DIV 4'h5
`define PSCL_W_CH_MUTE 4'h6
`define PSCL_W_MUTE_LVL_LO 4'h7
`define PSCL_W_MUTE_LVL_HI 4'h8
`define PSCL_W_CH_FMT 4'h9
`define PSCL_W_LAST 4'h9

// ===========================================================
// hardware default image, word 9 in the top byte
// mute enable 0x1 and mute level 0x3 on every channel
`define PSCL_CFG_DEFAULT 80'hff_ff_ff_ff_00_00_00_00_00_00

// ===========================================================
// strap codes and address
`define PSCL_TRI_GND 2'h0
`define PSCL_TRI_MID 2'h1
`define PSCL_TRI_VDD 2'h2
`define PSCL_ADDR_GND 2'h0
`define PSCL_ADDR_MID 2'h1
`define PSCL_ADDR_VDD 2'h3
`define PSCL_ROM_ADDR_LSB 2'h0

`endif

// file: sim/pscl_loader_asserts.sv
// Purpose: port checker for the strap configuration loader
// Assumes: eight channels, word map of pscl_regs.svh
// Notes: mode pin only moves while powered down
`timescale 1ns/1ps
`default_nettype none
module pscl_loader_asserts #(
   parameter int NCH = 8
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic config_source_select,
   input wire logic powerdown_input,
   input wire logic [5:0] strap_two_state,
   input wire logic page_rd_req,
   input wire logic page_rd_rom,
   input wire logic host_wr_en,
   input wire logic [3:0] host_wr_addr,
   input wire logic [7:0] host_wr_data,
   input wire logic host_ready,
   input wire logic host_if_en,
   input wire logic [1:0] target_addr_lsb,
   input wire logic [79:0] cfg_words,
   input wire logic div_sync,
   input wire logic outputs_enable,
   input wire logic [NCH-1:0] src_valid,
   input wire logic [NCH-1:0] ch_muted,
   input wire logic [NCH-1:0] ch_mute_p,
   input wire logic [NCH-1:0] ch_mute_n
);
   // ===========================================================
   // expected mute pattern, a cycle ahead of the drivers
   logic [NCH-1:0] mu_x;
   logic [NCH-1:0] p_x;
   logic [NCH-1:0] n_x;
   always_comb
   begin
      for (int i = 0; i < NCH; i++)
      begin
         mu_x[i] = cfg_words[48+i] & ~src_valid[i];
         p_x[i] = mu_x[i] & cfg_words[72+i] & cfg_words[56+2*i];
         n_x[i] = mu_x[i] & cfg_words[72+i] & ~cfg_words[57+2*i];
      end
   end
   // ===========================================================
   // properties
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   a_out_off_pd: assert property (powerdown_input |=> !outputs_enable)
      else $error("outputs on while powered down");
   a_host_gate: assert property (host_ready |-> host_if_en && !powerdown_input)
      else $error("host accepted outside run");
   a_host_write_lands: assert property (host_wr_en && host_ready && host_wr_addr <= 4'h9
      |=> cfg_words[$past(host_wr_addr)*8 +: 8] == $past(host_wr_data))
      else $error("host write not applied");
   a_rom_addr_zero: assert property (host_if_en && config_source_select && !powerdown_input
      |-> target_addr_lsb == 2'h0)
      else $error("address lsb not zero");
   a_rom_sync_entry: assert property ($rose(host_if_en) && config_source_select |-> div_sync)
      else $error("no sync at start");
   a_eep_sync_fall: assert property (host_if_en && !config_source_select && !powerdown_input
      && $fell(strap_two_state[0]) |=> div_sync)
      else $error("sync strap ignored");
   a_sync_single: assert property (div_sync |=> !div_sync)
      else $error("sync pulse too long");
   a_read_mode: assert property (page_rd_req |-> page_rd_rom == config_source_select)
      else $error("wrong page store");
   a_mute_follow: assert property (!powerdown_input |=> ch_muted == $past(mu_x))
      else $error("mute state wrong");
   a_mute_pos_node: assert property (!powerdown_input |=> ch_mute_p == $past(p_x))
      else $error("muted positive node wrong");
   a_mute_neg_node: assert property (!powerdown_input |=> ch_mute_n == $past(n_x))
      else $error("muted negative node wrong");
endmodule
bind pscl_loader pscl_loader_asserts #(.NCH(NCH)) u_chk (.clk, .srst, .config_source_select,
   .powerdown_input, .strap_two_state, .page_rd_req, .page_rd_rom, .host_wr_en, .host_wr_addr,
   .host_wr_data, .host_ready, .host_if_en, .target_addr_lsb, .cfg_words, .div_sync, .outputs_enable,
   .src_valid, .ch_muted, .ch_mute_p, .ch_mute_n);
`default_nettype wire

// file: sim/pscl_store.sv
// Purpose: page store model answering the loader's read port
// Assumes: one read outstanding at a time
// Notes: data wanders while idle so a stale byte is never taken
`timescale 1ns/1ps
`default_nettype none
module pscl_store (
   input wire logic clk,
   input wire logic srst,
   input wire logic req,
   input wire logic rom,
   input wire logic [5:0] page,
   input wire logic [3:0] word,
   input wire logic slow,
   output logic valid,
   output logic [7:0] data
);
   logic busy_q; // read pending
   logic [2:0] wait_q; // cycles left before answering
   // ===========================================================
   // answer each read after zero or five idle cycles
   always_ff @(posedge clk)
   begin
      valid <= 1'b0;
      data <= srst ? 8'h5a : ~data;
      if (srst)
         busy_q <= 1'b0;
      else if (req)
      begin
         busy_q <= 1'b1;
         wait_q <= slow ? 3'h5 : 3'h0;
      end
      else if (busy_q && wait_q != 3'h0)
         wait_q <= wait_q - 3'h1;
      else if (busy_q)
      begin
         busy_q <= 1'b0;
         valid <= 1'b1;
         data <= {2'h0, page} + {rom, 3'h0, word};
      end
   end
endmodule
`default_nettype wire

// file: sim/tb.sv
// Purpose: self-checking bench of the strap configuration loader
// Assumes: 40 MHz clock, store model on the read port
// Notes: loads are scored from a queue of notes
`timescale 1ns/1ps
`default_nettype none
`include "pscl_regs.svh"
module tb;
   typedef struct packed {logic [79:0] cfg; logic [1:0] addr; logic men; logic [2:0] msel; logic inv; logic rom;} pscl_note_t;
   logic clk, srst, config_source_select, powerdown_input, host_wr_en, page_rd_req, page_rd_rom, page_rd_valid;
   logic host_ready, host_if_en, margin_en, page_invalid, div_sync, outputs_enable, slow;
   logic [5:0] strap_two_state, page_rd_page;
   logic [1:0] strap1_tri, strap2_tri, strap3_tri, target_addr_lsb;
   logic [2:0] strap5_level, margin_sel;
   logic [3:0] page_rd_word, host_wr_addr;
   logic [7:0] page_rd_data, host_wr_data, src_valid, ch_muted, ch_mute_p, ch_mute_n;
   logic [79:0] cfg_words, exp_cfg;
   logic [31:0] seed = 32'haa9d978f;
   logic [31:0] r;
   logic seen = 1'b0;
   int error_cnt = 0;
   int comparisons = 0;
   int cyc = 0;
   pscl_note_t notes[$];
   pscl_loader #(.NCH(8)) u_dut (.clk, .srst, .config_source_select, .powerdown_input, .strap_two_state,
      .strap1_tri, .strap2_tri, .strap3_tri, .strap5_level, .page_rd_req, .page_rd_rom, .page_rd_page,
      .page_rd_word, .page_rd_valid, .page_rd_data, .host_wr_en, .host_wr_addr, .host_wr_data, .host_ready,
      .host_if_en, .target_addr_lsb, .margin_en, .margin_sel, .page_invalid, .cfg_words, .div_sync,
      .outputs_enable, .src_valid, .ch_muted, .ch_mute_p, .ch_mute_n);
   pscl_store u_store (.clk, .srst, .req(page_rd_req), .rom(page_rd_rom), .page(page_rd_page),
      .word(page_rd_word), .slow, .valid(page_rd_valid), .data(page_rd_data));
   // ===========================================================
   // clock, watchdog, helpers
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc++;
      if (cyc > 20000)
      begin
         error_cnt++;
         give_verdict();
      end
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // forced node level of each muted channel: differential only, level bit 0 or inverse of bit 1
   function automatic logic [7:0] mute_node(input logic [79:0] c, input logic [7:0] v, input logic neg);
      logic [7:0] m;
      m = c[55:48] & ~v & c[79:72];
      for (int j = 0; j < 8; j++)
         mute_node[j] = m[j] & (neg ? ~c[57+2*j] : c[56+2*j]);
   endfunction
   task automatic chk(input string what, input logic [79:0] exp, input logic [79:0] got);
      comparisons++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // one host update, back to back when called in a row
   task automatic hw(input logic [3:0] a, input logic [7:0] d);
      host_wr_en = 1'b1;
      host_wr_addr = a;
      host_wr_data = d;
      @(posedge clk);
      #1;
      if (a <= 4'h9)
         exp_cfg[a*8 +: 8] = d;
   endtask
   // power cycle with new straps; note the expected load first
   task automatic boot(input logic rom, input logic [1:0] t3, input logic [1:0] t2, input logic [1:0] t1);
      pscl_note_t n;
      int idx;
      int pg;
      r = rnd();
      powerdown_input = 1'b1;
      config_source_select = rom;
      strap_two_state = rom ? r[5:0] : {r[5:1], 1'b1};
      strap1_tri = t1;
      strap2_tri = t2;
      strap3_tri = t3;
      strap5_level = r[10:8];
      slow = r[12];
      repeat (3) @(posedge clk);
      #1;
      chk("outputs_enable", 1'b0, outputs_enable);
      chk("host_ready", 1'b0, host_ready);
      idx = 3 * t3 + t2;
      pg = rom ? int'(r[5:0]) : (idx > 4 ? idx - 1 : idx);
      n.cfg = `PSCL_CFG_DEFAULT;
      if (rom || (idx != 4 && idx < 7))
         for (int w = 0; w < 10; w++)
            n.cfg[w*8 +: 8] = {2'h0, 6'(pg)} + {rom, 3'h0, 4'(w)};
      n.addr = rom ? 2'h0 : (t1 == 2'h2 ? 2'h3 : t1);
      n.men = rom ? 1'b0 : r[4];
      n.msel = rom ? 3'h0 : r[10:8];
      n.inv = !rom && idx >= 7;
      n.rom = rom;
      notes.push_back(n);
      exp_cfg = n.cfg;
      powerdown_input = 1'b0;
      for (int k = 0; k < 300 && host_if_en !== 1'b1; k++)
      begin
         @(posedge clk);
         #1;
      end
      chk("host_if_en", 1'b1, host_if_en);
      strap1_tri = (t1 == 2'h0) ? 2'h2 : 2'h0;
      strap_two_state[5:1] = ~strap_two_state[5:1];
      strap5_level = ~r[10:8];
      repeat (3) @(posedge clk);
      #1;
      chk("target_addr_lsb", n.addr, target_addr_lsb);
      chk("margin_en", n.men, margin_en);
      chk("cfg_words", exp_cfg, cfg_words);
      chk("margin_sel", n.msel, margin_sel);
      chk("outputs_enable", 1'b1, outputs_enable);
      chk("host_ready", 1'b1, host_ready);
   endtask
   // ===========================================================
   // scoreboard: each finished load against the oldest note
   always @(posedge clk)
   begin
      pscl_note_t n;
      #2;
      if (host_if_en === 1'b1 && !seen && notes.size() > 0)
      begin
         n = notes.pop_front();
         chk("cfg_words", n.cfg, cfg_words);
         chk("target_addr_lsb", n.addr, target_addr_lsb);
         chk("margin_en", n.men, margin_en);
         chk("page_invalid", n.inv, page_invalid);
         chk("div_sync", n.rom, div_sync);
         chk("margin_sel", n.msel, margin_sel);
      end
      seen = (host_if_en === 1'b1);
   end
   // ===========================================================
   // main sequence
   initial
   begin
      srst = 1'b1;
      powerdown_input = 1'b1;
      config_source_select = 1'b1;
      strap_two_state = 6'h00;
      strap1_tri = 2'h0;
      strap2_tri = 2'h0;
      strap3_tri = 2'h0;
      strap5_level = 3'h0;
      host_wr_en = 1'b0;
      host_wr_addr = 4'h0;
      host_wr_data = 8'h00;
      src_valid = 8'hff;
      slow = 1'b0;
      repeat (12) @(posedge clk);
      #1;
      srst = 1'b0;
      boot(1'b1, 2'h0, 2'h0, 2'h0);
      $display("test rom load done");
      for (int i = 0; i < 12; i++)
         hw(4'(i), 8'(rnd()));
      host_wr_en = 1'b0;
      chk("cfg_words", exp_cfg, cfg_words);
      $display("test host writes done");
      for (int i = 0; i < 8; i++)
      begin
         src_valid = (i == 0) ? 8'h00 : 8'(rnd());
         @(posedge clk);
         #1;
         chk("ch_muted", exp_cfg[55:48] & ~src_valid, ch_muted);
         chk("ch_mute_p", mute_node(exp_cfg, src_valid, 1'b0), ch_mute_p);
         chk("ch_mute_n", mute_node(exp_cfg, src_valid, 1'b1), ch_mute_n);
      end
      $display("test mute done");
      for (int c = 0; c < 9; c++)
      begin
         boot(1'b0, 2'(c / 3), 2'(c % 3), 2'(c % 3));
         strap_two_state[0] = 1'b0;
         @(posedge clk);
         #1;
         chk("div_sync", 1'b1, div_sync);
         strap_two_state[0] = 1'b1;
      end
      $display("test strap pages done");
      boot(1'b1, 2'h1, 2'h1, 2'h1);
      $display("test return to rom done");
      chk("notes_left", 80'h0, 80'(notes.size()));
      give_verdict();
   end
endmodule
`default_nettype wire
